// File: core/pstc_pkg.sv
// Shared constants and types of the pattern sequencer and trigger controller.
// Assumes one 40 MHz clock and a synchronous, active-high reset.
package pstc_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
	localparam int unsigned DARK_CYCLES   = 1;

	// ------------------------------------------------------------
	// Plane store geometry
	// ------------------------------------------------------------
	localparam int unsigned NUM_BUFS       = 2;
	localparam int unsigned PLANES_PER_BUF = 24;
	localparam int unsigned TOTAL_PLANES   = NUM_BUFS * PLANES_PER_BUF;
	localparam int unsigned PAT_W          = PLANES_PER_BUF;
	localparam int unsigned NUM_COLORS     = 3;
	localparam int unsigned COLOR_IN_BITS  = 10;
	localparam int unsigned COLOR_PAT_BITS = 8;
	localparam int unsigned PIX_IN_BITS    = NUM_COLORS * COLOR_IN_BITS;
	localparam int unsigned FRAME_WORDS    = 16;
	localparam int unsigned FIFO_DEPTH     = 32;

	// ------------------------------------------------------------
	// Sequencer widths and limits
	// ------------------------------------------------------------
	localparam int unsigned MAX_DEPTH = 8;
	localparam int unsigned IDX_W     = 6;
	localparam int unsigned ORDER_LEN = 64;
	localparam int unsigned PLANE_W   = 5;
	localparam int unsigned DEPTH_W   = 4;
	localparam int unsigned SUB_W     = 2;
	localparam int unsigned NUM_SUBS  = 3;
	localparam int unsigned CNT_W     = 24;

	// Highest pattern rates per bit depth 1..8
	localparam int unsigned RATE_PRE_HZ [MAX_DEPTH] = '{4225, 1428, 636, 588, 500, 400, 222, 120};
	localparam int unsigned RATE_STR_HZ [MAX_DEPTH] = '{2880, 1428, 636, 588, 480, 400, 222, 120};

	// ------------------------------------------------------------
	// Trigger modes, reset values and states
	// ------------------------------------------------------------
	localparam logic [1:0] TRIG_MODE_VSYNC   = 2'h0;
	localparam logic [1:0] TRIG_MODE_ADVANCE = 2'h1;
	localparam logic [1:0] TRIG_MODE_PAIR    = 2'h2;
	localparam logic       ACT_BUF_RST       = 1'h0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT,
		ST_PREP,
		ST_EXPOSE,
		ST_DARK,
		ST_HALT
	} pstc_state_e;

endpackage

// File: core/pstc_fifo.sv
// Word FIFO between the pattern loader and the plane store.
// Assumes one clock and a synchronous, active-high reset; ready is registered.
module pstc_fifo #(
	parameter int unsigned WIDTH = pstc_pkg::PAT_W,
	parameter int unsigned DEPTH = pstc_pkg::FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             ready_reg;

	// Handshakes and next fill level
	wire          push       = in_valid & ready_reg;
	wire          pop        = out_valid & out_ready;
	wire [AW:0]   count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);

	assign in_ready  = ready_reg;
	assign out_valid = (count_reg != '0);
	assign out_data  = mem_reg[rd_ptr_reg];

	// Pointer wrap for depths that are not a power of two
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// Ready is a flop so the source never sees a comparator path
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			ready_reg  <= 1'b1;
		end else begin
			if (push) begin
				mem_reg[wr_ptr_reg] <= in_data;
				wr_ptr_reg          <= bump(wr_ptr_reg);
			end
			if (pop) begin
				rd_ptr_reg <= bump(rd_ptr_reg);
			end
			count_reg <= count_next;
			ready_reg <= (count_next != (AW + 1)'(DEPTH));
		end
	end

endmodule

// File: core/pstc_top.sv
// Pattern sequencer and trigger controller: double-buffered plane store,
// loader from flash or the parallel pixel port, sequencer and camera triggers.
// Assumes one clock, a synchronous active-high reset, configuration inputs
// held steady while running, and a formatter reading the shown buffer.
//
// Operation
// - Two 24-plane buffers, 48 planes; one shows while the other fills.
// - Streaming shows the previous frame while the current one is written.
// - After a buffer's planes are shown, roles swap to the other buffer.
// - All 48 planes preload from flash; configurable order and bit depth.
// - Peak rate needs one buffer half consumed before the other half.
// - Pattern sets beyond the store wait for a reload of a half.
// - Three trigger modes, zero to two, each giving inputs different meaning.
// - Mode zero triggers on vertical sync and ignores the advance input.
// - Modes zero and one: start/stop rise starts, fall stops the sequence.
// - Mode one: each advance pulse moves to the next pattern.
// - Mode two: advance input toggles between two consecutive patterns.
// - Mode two: start/stop pulse moves to the next pair of patterns.
// - Exposure output high for the whole exposure of each shown pattern.
// - Sequence-start output pulses at the beginning of each sequence.
// - A colour pattern shows as three time-sequential sub-patterns.
// - Modes zero and one: start/stop low halts; high again re-shows the interrupted pattern.
// - Pattern count limited by depth: 48,24,16,12,8,8,6,6.
// - Exposure never shorter than the peak rate of the chosen depth allows.
// - Planes go straight to time slots; triggers align with those slots.
// - Pixel input keeps the upper eight bits of each ten-bit colour.
module pstc_top #(
	parameter int unsigned CLK_HZ      = pstc_pkg::CLK_HZ,
	parameter int unsigned FRAME_WORDS = pstc_pkg::FRAME_WORDS,
	parameter int unsigned FIFO_DEPTH  = pstc_pkg::FIFO_DEPTH,
	parameter int unsigned AW          = (FRAME_WORDS > 1) ? $clog2(FRAME_WORDS) : 1
) (
	input  wire logic                                       clk,
	input  wire logic                                       rst,
	input  wire logic [1:0]                                 trig_mode,
	input  wire logic                                       stream_mode,
	input  wire logic                                       color_pattern,
	input  wire logic [pstc_pkg::DEPTH_W-1:0]               bit_depth,
	input  wire logic [pstc_pkg::IDX_W-1:0]                 seq_len,
	input  wire logic [pstc_pkg::CNT_W-1:0]                 exposure_cycles,
	input  wire logic [pstc_pkg::ORDER_LEN-1:0][pstc_pkg::IDX_W-1:0] pattern_order,
	input  wire logic [pstc_pkg::PIX_IN_BITS-1:0]           px_data,
	input  wire logic                                       px_valid,
	input  wire logic [pstc_pkg::PAT_W-1:0]                 flash_data,
	input  wire logic                                       flash_valid,
	output logic                                            load_ready,
	input  wire logic                                       vsync,
	input  wire logic                                       advance_trigger_input,
	input  wire logic                                       start_stop_trigger_input,
	output logic                                            exposure_active_output,
	output logic                                            sequence_start_output,
	output logic                                            plane_buffer,
	output logic [pstc_pkg::PLANE_W-1:0]                    plane_first,
	output logic [pstc_pkg::DEPTH_W-1:0]                    plane_depth,
	output logic [pstc_pkg::SUB_W-1:0]                      sub_pattern,
	output logic                                            seq_running,
	output logic                                            reload_wait,
	input  wire logic [AW-1:0]                              fmt_rd_addr,
	output logic [pstc_pkg::PAT_W-1:0]                      fmt_rd_data
);
	localparam int unsigned IW = pstc_pkg::IDX_W;
	localparam int unsigned CW = pstc_pkg::CNT_W;
	localparam int unsigned PW = pstc_pkg::PAT_W;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	pstc_pkg::pstc_state_e state_reg;
	pstc_pkg::pstc_state_e state_next;
	logic [2:0]                       sync1_reg;
	logic [2:0]                       sync2_reg;
	logic [2:0]                       sync3_reg;
	logic [IW-1:0]                    idx_reg;
	logic [IW-1:0]                    idx_next;
	logic [pstc_pkg::SUB_W-1:0]       sub_reg;
	logic [pstc_pkg::SUB_W-1:0]       sub_next;
	logic [CW-1:0]                    cnt_reg;
	logic [CW-1:0]                    cnt_next;
	logic                             act_reg;
	logic                             act_next;
	logic [pstc_pkg::NUM_BUFS-1:0]    valid_reg;
	logic                             release_en;
	logic                             start_next;
	logic                             wr_busy_reg;
	logic                             wr_buf_reg;
	logic [AW-1:0]                    wr_ptr_reg;
	logic [PW-1:0]                    store_reg [pstc_pkg::NUM_BUFS][FRAME_WORDS];
	logic                             exp_reg;
	logic                             start_reg;
	logic [pstc_pkg::PLANE_W-1:0]     first_reg;
	logic [pstc_pkg::DEPTH_W-1:0]     depth_reg;
	logic                             running_reg;
	logic                             reload_reg;
	logic [PW-1:0]                    rd_data_reg;
	logic                             fifo_valid;
	logic [PW-1:0]                    fifo_data;

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Patterns that fit one buffer half at depth d
	function automatic logic [IW-1:0] pats_per_buf(input logic [pstc_pkg::DEPTH_W-1:0] d);
		logic [IW-1:0] r;
		r = IW'(pstc_pkg::PLANES_PER_BUF);
		for (int i = 1; i <= pstc_pkg::MAX_DEPTH; i++) begin
			if (d == pstc_pkg::DEPTH_W'(i)) begin
				r = IW'(pstc_pkg::PLANES_PER_BUF / i);
			end
		end
		return r;
	endfunction

	// Shortest exposure for the peak rate of a depth; each divide folds to a constant
	function automatic logic [CW-1:0] min_period(input logic [pstc_pkg::DEPTH_W-1:0] d,
		input logic strm);
		logic [CW-1:0] r;
		r = CW'(1);
		for (int i = 0; i < pstc_pkg::MAX_DEPTH; i++) begin
			if (d == pstc_pkg::DEPTH_W'(i + 1)) begin
				r = strm ? CW'(CLK_HZ / pstc_pkg::RATE_STR_HZ[i])
					: CW'(CLK_HZ / pstc_pkg::RATE_PRE_HZ[i]);
			end
		end
		return (r == '0) ? CW'(1) : r;
	endfunction

	// Index wrap at the sequence length
	function automatic logic [IW-1:0] wrap_idx(input logic [IW:0] v, input logic [IW-1:0] len);
		return (v >= {1'b0, len}) ? '0 : v[IW-1:0];
	endfunction

	// Upper eight bits of each ten-bit colour form the pattern word
	function automatic logic [PW-1:0] pix_to_pat(input logic [pstc_pkg::PIX_IN_BITS-1:0] p);
		logic [PW-1:0] r;
		r = '0;
		for (int c = 0; c < pstc_pkg::NUM_COLORS; c++) begin
			r[c * pstc_pkg::COLOR_PAT_BITS +: pstc_pkg::COLOR_PAT_BITS] =
				p[c * pstc_pkg::COLOR_IN_BITS + (pstc_pkg::COLOR_IN_BITS
				- pstc_pkg::COLOR_PAT_BITS) +: pstc_pkg::COLOR_PAT_BITS];
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Trigger synchronisers and edges
	// ------------------------------------------------------------

	// Bit 0 vsync, bit 1 advance, bit 2 start/stop; stage one feeds stage two only
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else begin
			sync1_reg <= {start_stop_trigger_input, advance_trigger_input, vsync};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// Edge terms and mode decode
	wire vs_rise   = sync2_reg[0] & ~sync3_reg[0];
	wire adv_rise  = sync2_reg[1] & ~sync3_reg[1];
	wire ss_rise   = sync2_reg[2] & ~sync3_reg[2];
	wire ss_fall   = ~sync2_reg[2] & sync3_reg[2];
	wire mode_pair = (trig_mode == pstc_pkg::TRIG_MODE_PAIR);
	wire step_go   = (trig_mode == pstc_pkg::TRIG_MODE_ADVANCE) ? adv_rise : vs_rise;
	wire stop_req  = ~mode_pair & ss_fall;

	// ------------------------------------------------------------
	// Pattern geometry
	// ------------------------------------------------------------

	// Depth clamped to 1..8; zero reads as one
	wire [pstc_pkg::DEPTH_W-1:0] depth = (bit_depth == '0) ? pstc_pkg::DEPTH_W'(1)
		: (bit_depth > pstc_pkg::DEPTH_W'(pstc_pkg::MAX_DEPTH))
		? pstc_pkg::DEPTH_W'(pstc_pkg::MAX_DEPTH) : bit_depth;
	wire [IW-1:0] ppb       = pats_per_buf(depth);
	wire [IW-1:0] max_pat   = IW'({ppb, 1'b0});
	// Longer sets and streaming recycle halves and pay the reload wait
	wire          reload_en = stream_mode | (seq_len > max_pat);
	wire [IW-1:0] eff_len   = (seq_len == '0) ? max_pat : seq_len;

	// Slot from the order table, or linear when streaming
	wire [IW-1:0] slot     = stream_mode ? idx_reg : pattern_order[idx_reg];
	wire          need_buf = (slot >= ppb);
	wire [IW-1:0] rel_raw  = need_buf ? slot - ppb : slot;
	wire [IW-1:0] rel      = (rel_raw >= ppb) ? '0 : rel_raw;
	wire [pstc_pkg::PLANE_W-1:0] first_plane =
		pstc_pkg::PLANE_W'(rel * {2'h0, depth});
	wire          need_ok  = valid_reg[need_buf];

	// Exposure length never beats the rate limit of the depth
	wire [CW-1:0] min_cyc = min_period(depth, stream_mode);
	wire [CW-1:0] exp_len = (exposure_cycles > min_cyc) ? exposure_cycles : min_cyc;

	// Next indices for each trigger meaning
	wire [IW-1:0] idx_step   = wrap_idx({1'b0, idx_reg} + (IW + 1)'(1), eff_len);
	wire [IW-1:0] idx_tog    = wrap_idx({1'b0, idx_reg[IW-1:1], ~idx_reg[0]}, eff_len);
	wire [IW-1:0] idx_toggle = (idx_tog == '0) ? {idx_reg[IW-1:1], 1'b0} : idx_tog;
	wire [IW-1:0] idx_pair   = wrap_idx({1'b0, idx_reg[IW-1:1], 1'b0} + (IW + 1)'(2), eff_len);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------

	// Pattern walk: wait for a trigger, expose, dark gap, then the next slot
	always_comb begin
		state_next = state_reg;
		idx_next   = idx_reg;
		sub_next   = sub_reg;
		cnt_next   = cnt_reg;
		act_next   = act_reg;
		release_en = 1'b0;
		start_next = 1'b0;
		case (state_reg)
			pstc_pkg::ST_IDLE: begin
				if (mode_pair && (adv_rise || ss_rise)) begin
					idx_next   = '0;
					state_next = pstc_pkg::ST_PREP;
				end else if (!mode_pair && ss_rise) begin
					idx_next   = '0;
					state_next = pstc_pkg::ST_WAIT;
				end
			end
			pstc_pkg::ST_WAIT, pstc_pkg::ST_HALT: begin
				if (mode_pair && adv_rise) begin
					idx_next   = idx_toggle;
					state_next = pstc_pkg::ST_PREP;
				end else if (mode_pair && ss_rise) begin
					idx_next   = idx_pair;
					state_next = pstc_pkg::ST_PREP;
				end else if (stop_req) begin
					state_next = pstc_pkg::ST_HALT;
				end else if (state_reg == pstc_pkg::ST_HALT && !mode_pair && ss_rise) begin
					state_next = pstc_pkg::ST_PREP;
				end else if (state_reg == pstc_pkg::ST_WAIT && !mode_pair && step_go) begin
					state_next = pstc_pkg::ST_PREP;
				end
			end
			pstc_pkg::ST_PREP: begin
				// Missing half: hold here until the loader finishes it
				if (stop_req) begin
					state_next = pstc_pkg::ST_HALT;
				end else if (need_ok) begin
					act_next   = need_buf;
					release_en = (need_buf != act_reg) & reload_en;
					sub_next   = '0;
					cnt_next   = '0;
					start_next = (idx_reg == '0);
					state_next = pstc_pkg::ST_EXPOSE;
				end
			end
			pstc_pkg::ST_EXPOSE: begin
				cnt_next = cnt_reg + CW'(1);
				if (stop_req) begin
					state_next = pstc_pkg::ST_HALT;
				end else if (cnt_reg == exp_len - CW'(1)) begin
					cnt_next   = '0;
					state_next = pstc_pkg::ST_DARK;
				end
			end
			pstc_pkg::ST_DARK: begin
				cnt_next = cnt_reg + CW'(1);
				if (stop_req) begin
					state_next = pstc_pkg::ST_HALT;
				end else if (cnt_reg == CW'(pstc_pkg::DARK_CYCLES - 1)) begin
					cnt_next = '0;
					if (color_pattern && sub_reg != pstc_pkg::SUB_W'(pstc_pkg::NUM_SUBS - 1)) begin
						sub_next   = sub_reg + pstc_pkg::SUB_W'(1);
						state_next = pstc_pkg::ST_EXPOSE;
					end else begin
						state_next = pstc_pkg::ST_WAIT;
						if (!mode_pair) begin
							idx_next = idx_step;
						end
					end
				end
			end
			default: begin
				state_next = pstc_pkg::ST_IDLE;
			end
		endcase
	end

	// Sequencer state flops
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= pstc_pkg::ST_IDLE;
			idx_reg   <= '0;
			sub_reg   <= '0;
			cnt_reg   <= '0;
			act_reg   <= pstc_pkg::ACT_BUF_RST;
		end else begin
			state_reg <= state_next;
			idx_reg   <= idx_next;
			sub_reg   <= sub_next;
			cnt_reg   <= cnt_next;
			act_reg   <= act_next;
		end
	end

	// Trigger and formatter outputs, all registered
	always_ff @(posedge clk) begin
		if (rst) begin
			exp_reg     <= 1'b0;
			start_reg   <= 1'b0;
			first_reg   <= '0;
			depth_reg   <= '0;
			running_reg <= 1'b0;
			reload_reg  <= 1'b0;
		end else begin
			exp_reg     <= (state_next == pstc_pkg::ST_EXPOSE);
			start_reg   <= start_next;
			running_reg <= (state_next != pstc_pkg::ST_IDLE) && (state_next != pstc_pkg::ST_HALT);
			reload_reg  <= (state_reg == pstc_pkg::ST_PREP) & ~need_ok;
			if (state_reg == pstc_pkg::ST_PREP && state_next == pstc_pkg::ST_EXPOSE) begin
				first_reg <= first_plane;
				depth_reg <= depth;
			end
		end
	end

	assign exposure_active_output = exp_reg;
	assign sequence_start_output  = start_reg;
	assign plane_buffer           = act_reg;
	assign plane_first            = first_reg;
	assign plane_depth            = depth_reg;
	assign sub_pattern            = sub_reg;
	assign seq_running            = running_reg;
	assign reload_wait            = reload_reg;
	assign fmt_rd_data            = rd_data_reg;

	// ------------------------------------------------------------
	// Loader and plane store
	// ------------------------------------------------------------

	// Source select; both sources share one FIFO and one ready
	wire          src_valid = stream_mode ? px_valid : flash_valid;
	wire [PW-1:0] src_data  = stream_mode ? pix_to_pat(px_data) : flash_data;

	// Fill target: the shown half only before first use, else the other half.
	// A valid shown half is never written, so the writer never tears it.
	wire wr_sel  = wr_busy_reg ? wr_buf_reg : (valid_reg[act_reg] ? ~act_reg : act_reg);
	wire wr_can  = wr_busy_reg | ~valid_reg[wr_sel];
	wire wr_fire = fifo_valid & wr_can;
	wire wr_done = wr_fire & (wr_ptr_reg == AW'(FRAME_WORDS - 1));

	pstc_fifo #(
		.WIDTH (PW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (src_valid),
		.in_ready  (load_ready),
		.in_data   (src_data),
		.out_valid (fifo_valid),
		.out_ready (wr_can),
		.out_data  (fifo_data)
	);

	// Frame writer; a finishing fill beats a release of the same half
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_busy_reg <= 1'b0;
			wr_buf_reg  <= 1'b0;
			wr_ptr_reg  <= '0;
			valid_reg   <= '0;
		end else begin
			if (wr_fire) begin
				store_reg[wr_sel][wr_ptr_reg] <= fifo_data;
				wr_buf_reg  <= wr_sel;
				wr_busy_reg <= ~wr_done;
				wr_ptr_reg  <= wr_done ? '0 : wr_ptr_reg + AW'(1);
			end
			if (release_en) begin
				valid_reg[act_reg] <= 1'b0;
			end
			if (wr_done) begin
				valid_reg[wr_sel] <= 1'b1;
			end
		end
	end

	// Formatter read of the shown half, one cycle latency
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data_reg <= '0;
		end else begin
			rd_data_reg <= store_reg[act_reg][fmt_rd_addr];
		end
	end

endmodule

// File: tb/pstc_props.sv
// Checker of the sequencer's camera triggers, bound to pstc_top.
// Assumes one clock and a synchronous active-high reset.
module pstc_props (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [1:0] trig_mode,
	input wire logic       start_stop_trigger_input,
	input wire logic       load_ready,
	input wire logic       exposure_active_output,
	input wire logic       sequence_start_output,
	input wire logic       plane_buffer,
	input wire logic       seq_running
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// ------
	// Trigger outputs
	// ------
	seq_start_a: assert property (sequence_start_output |-> $rose(exposure_active_output))
		else $error("sequence mark off exposure start");
	seq_pulse_a: assert property (sequence_start_output |=> !sequence_start_output)
		else $error("sequence mark too long");
	exp_hold_a: assert property ($rose(exposure_active_output) |-> exposure_active_output[*4])
		else $error("exposure closed early");
	dark_mark_a: assert property ($fell(exposure_active_output) |=> !sequence_start_output)
		else $error("sequence mark after a dark gap");
	run_gate_a: assert property ($rose(exposure_active_output) |-> seq_running)
		else $error("exposure while idle");
	// Sync delay is three clocks, so six low samples must have stopped everything
	halt_stop_a: assert property (
		(trig_mode != 2'h2 && !start_stop_trigger_input)[*6] |=> !exposure_active_output && !seq_running)
		else $error("no halt on low start");
	start_need_a: assert property (
		$rose(seq_running) && trig_mode != 2'h2 |-> $past(start_stop_trigger_input, 2))
		else $error("run without start");
	load_rst_a: assert property ($fell(rst) |-> load_ready && !plane_buffer)
		else $error("bad state after reset");
endmodule

bind pstc_top pstc_props chk (.clk, .rst, .trig_mode, .start_stop_trigger_input, .load_ready,
	.exposure_active_output, .sequence_start_output, .plane_buffer, .seq_running);

// File: tb/pstc_host.sv
// Host and camera model: drives the trigger pins, counts and times exposures.
// Assumes the bench calls its tasks and shares clk.
module pstc_host (
	input  wire logic clk,
	input  wire logic exposure_active_output,
	input  wire logic sequence_start_output,
	output logic      vsync = 1'h0,
	output logic      advance_trigger_input = 1'h0,
	output logic      start_stop_trigger_input = 1'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	int   exp_n = 0;
	int   seq_n = 0;
	int   exp_len = 0;
	int   run = 0;
	logic exp_d = 1'h0;
	// Pins change just after an edge; sel 2 and 3 both reach start/stop
	task automatic drive(input int sel, input logic v);
		if (sel == 0) vsync <= v;
		else if (sel == 1) advance_trigger_input <= v;
		else start_stop_trigger_input <= v;
	endtask
	// Four clocks wide so the synchroniser cannot miss it; sel 3 leaves start high
	task automatic pulse(input int sel);
		@(posedge clk);
		drive(sel, 1'h1);
		repeat (4) @(posedge clk);
		if (sel < 3) drive(sel, 1'h0);
	endtask
	// Camera side: count exposures and sequence marks, time each exposure
	always @(posedge clk) begin
		exp_d <= exposure_active_output;
		run <= exposure_active_output ? run + 1 : 0;
		if (exp_d && !exposure_active_output) exp_len <= run;
		if (exposure_active_output && !exp_d) exp_n <= exp_n + 1;
		if (sequence_start_output === 1'h1) seq_n <= seq_n + 1;
	end
endmodule

// File: tb/pstc_top_test.sv
// Bench: flash preload, the three trigger modes, halt and colour patterns.
// Assumes pstc_host drives the trigger pins; CLK_HZ shrunk for short exposures.
module pstc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk = 1'h0;
	logic             rst = 1'h1;
	logic [1:0]       trig_mode = 2'h0;
	logic             color_pattern = 1'h0;
	logic [3:0]       bit_depth = 4'h1;
	logic [5:0]       seq_len = 6'h4;
	logic [23:0]      exposure_cycles = 24'h00000C;
	logic [63:0][5:0] pattern_order = '0;
	logic [23:0]      flash_data = 24'h0;
	logic             flash_valid = 1'h0;
	logic [3:0]       fmt_rd_addr = 4'h0;
	logic [4:0]       shown = 5'h0;
	wire logic [4:0]  plane_first;
	wire logic [23:0] fmt_rd_data;
	wire logic        load_ready, exposure_active_output, sequence_start_output, plane_buffer;
	wire logic        seq_running, vsync, advance_trigger_input, start_stop_trigger_input;
	wire logic [3:0]  plane_depth;
	wire logic [1:0]  sub_pattern;
	wire logic        reload_wait;
	int               mismatches = 0;
	int               checks = 0;
	int unsigned      plane_of [4] = '{2, 5, 7, 9};

	pstc_top #(.CLK_HZ(40000)) dut (.clk, .rst, .trig_mode, .stream_mode(1'h0), .color_pattern,
		.bit_depth, .seq_len, .exposure_cycles, .pattern_order, .px_data(30'h0), .px_valid(1'h0),
		.flash_data, .flash_valid, .load_ready, .vsync, .advance_trigger_input,
		.start_stop_trigger_input, .exposure_active_output, .sequence_start_output, .plane_buffer,
		.plane_first, .plane_depth, .sub_pattern, .seq_running, .reload_wait, .fmt_rd_addr,
		.fmt_rd_data);
	pstc_host host (.clk, .exposure_active_output, .sequence_start_output, .vsync,
		.advance_trigger_input, .start_stop_trigger_input);

	// ------
	// Clock, plane capture and checking helpers
	// ------
	always #12.5 clk = ~clk;
	always @(posedge clk) if (exposure_active_output === 1'h1) shown <= plane_first;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			mismatches++;
			$display("ERROR %s expected %0h seen %0h", what, want, seen);
		end
	endtask
	task automatic give_verdict;
		if (mismatches == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Reset with a new mode, then offer n flash words and count those taken
	task automatic restart(input logic [1:0] mode, input logic col, input int n, input int want);
		int k;
		int t;
		logic r;
		k = 0;
		t = 0;
		@(posedge clk);
		rst <= 1'h1;
		trig_mode <= mode;
		color_pattern <= col;
		host.drive(2, 1'h0);
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		flash_valid <= 1'h1;
		while (k < n && t < 300) begin
			flash_data <= 24'(k * 24'h010101 + 1);
			@(negedge clk);
			r = load_ready;
			@(posedge clk);
			if (r === 1'h1) k++;
			t++;
		end
		flash_valid <= 1'h0;
		check("words taken", k, want);
	endtask
	// One trigger, then a bounded wait for n finished exposures
	task automatic step(input int sel, input int n, input logic [4:0] plane);
		int base;
		int k;
		base = host.exp_n;
		k = 0;
		host.pulse(sel);
		while ((host.exp_n < base + n || exposure_active_output !== 1'h0) && k < 400) begin
			@(posedge clk);
			k++;
		end
		if (k == 400) begin
			mismatches++;
			give_verdict();
		end
		check("exposures", host.exp_n - base, n);
		check("plane", shown, plane);
		check("depth", plane_depth, bit_depth);
	endtask

	// ------
	// Scenarios
	// ------
	task automatic t_vsync;
		int s0;
		restart(2'h0, 1'h0, 80, 64);
		fmt_rd_addr <= 4'h3;
		repeat (2) @(posedge clk);
		check("store word", fmt_rd_data, 24'h030304);
		check("shown half", plane_buffer, 1'h0);
		check("reload idle", reload_wait, 1'h0);
		host.pulse(3);
		s0 = host.exp_n;
		host.pulse(1);
		repeat (30) @(posedge clk);
		check("advance ignored", host.exp_n, s0);
		s0 = host.seq_n;
		for (int i = 0; i < 5; i++) step(0, 1, 5'(plane_of[i % 4]));
		check("sequence marks", host.seq_n - s0, 2);
		check("exposure length", host.exp_len, 12);
	endtask
	// Halt lands inside the third exposure; resume needs no step trigger
	task automatic t_advance;
		restart(2'h1, 1'h0, 32, 32);
		host.pulse(3);
		step(1, 1, 5'h2);
		step(1, 1, 5'h5);
		host.pulse(1);
		repeat (3) @(posedge clk);
		host.drive(2, 1'h0);
		repeat (6) @(posedge clk);
		check("halted run", seq_running, 1'h0);
		check("halted exposure", exposure_active_output, 1'h0);
		step(3, 1, 5'h7);
	endtask
	task automatic t_pair;
		exposure_cycles <= 24'h000002;
		bit_depth <= 4'h2;
		restart(2'h2, 1'h0, 32, 32);
		step(1, 1, 5'h4);
		step(1, 1, 5'hA);
		step(1, 1, 5'h4);
		step(2, 1, 5'hE);
		step(1, 1, 5'h12);
		check("floor length", host.exp_len, 40000 / pstc_pkg::RATE_PRE_HZ[1]);
	endtask
	task automatic t_colour;
		exposure_cycles <= 24'h00000C;
		bit_depth <= 4'h1;
		restart(2'h0, 1'h1, 32, 32);
		host.pulse(3);
		step(0, 3, 5'h2);
		check("sub pattern", sub_pattern, 2'h2);
	endtask

	// Main sequence: reset held two clocks, then each scenario in turn
	initial begin
		for (int i = 0; i < 4; i++) pattern_order[i] = 6'(plane_of[i]);
		repeat (2) @(posedge clk);
		t_vsync();
		t_advance();
		t_pair();
		t_colour();
		give_verdict();
	end
endmodule
